// [hdl/cvt_pkg.sv]
// Constants and carriers for the capture/compare value and trigger select block
package cvt_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [3:0] CVT_ADDR_VLOW  = 4'h0;  // value_low_byte
   localparam logic [3:0] CVT_ADDR_VHIGH = 4'h4;  // value_high_byte
   localparam logic [3:0] CVT_ADDR_TRIG  = 4'h8;  // trigger_source_register
   localparam logic [3:0] CVT_ADDR_CTRL  = 4'hc;  // mode and alignment_format_bit
   localparam logic [3:0] CVT_ADDR_TBASE = 4'h0;  // timebase_select_register, word 4 (see below)
   localparam logic [4:0] CVT_WORD_TBASE = 5'h10; // timebase_select_register byte address
   localparam logic [4:0] CVT_WORD_STAT  = 5'h14; // status: compare match, capture seen

   // ------------------------------------------------------------
   // Reset values and field positions
   // ------------------------------------------------------------
   localparam logic [7:0] CVT_RST_BYTE  = 8'h00;  // value and select registers clear on any reset
   localparam logic [3:0] CVT_RST_TRIG  = 4'h0;
   localparam logic [1:0] CVT_RST_MODE  = 2'h0;
   localparam int         CVT_FMT_POS   = 2;      // alignment_format_bit in control word
   localparam int         CVT_NUM_UNITS = 4;      // units with own timebase code
   localparam logic [1:0] CVT_CODE_FOURTH = 2'h3; // code of the fourth 8-bit timer

   // ------------------------------------------------------------
   // Trigger source codes
   // ------------------------------------------------------------
   localparam logic [3:0] CVT_TRIG_PIN   = 4'h0;
   localparam logic [3:0] CVT_TRIG_CMP1  = 4'h1;
   localparam logic [3:0] CVT_TRIG_CMP6  = 4'h6;
   localparam logic [3:0] CVT_TRIG_LC1   = 4'h9;
   localparam logic [3:0] CVT_TRIG_LC4   = 4'hc;
   localparam logic [3:0] CVT_TRIG_PCHG  = 4'hd;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CVT_MODE_OFF,
      CVT_MODE_CAPTURE,
      CVT_MODE_COMPARE,
      CVT_MODE_PWM
   } cvt_mode_type;

   typedef struct packed {
      logic [5:0] comparator_synced_output; // six comparator outputs
      logic [3:0] logic_cell_output;        // four logic-cell outputs
      logic       pin_change_event;
      logic       mapped_pin;               // pin from pin_mapping_select
   } cvt_trig_type;

   typedef struct packed {
      logic [7:0] t3;
      logic [7:0] t2;
      logic [7:0] t1;
      logic [7:0] t0;
   } cvt_timers_type;

endpackage

// [hdl/cvt_value_trigger.sv]
// Value registers, capture trigger select and timebase select of one CCP unit
//
// Behaviour
// RULE_01: Capture loads timer bits into low/high bytes
// RULE_02: Compare mode compares value pair with timer
// RULE_03: Right-aligned width: low byte, high bits 1..0
// RULE_04: Left-aligned width bits 9..2 from high byte
// RULE_05: Left-aligned width bits 1..0 from low 7..6
// RULE_06: Four-bit field selects comparator, cell, pin-change
// RULE_07: Code zero uses the mapped input pin
// RULE_08: Trigger register upper nibble reads zero
// RULE_09: All value and select registers reset to zero
// RULE_10: Each unit has its own timebase code
// RULE_11: Any of four 8-bit timers usable for PWM
// RULE_12: Codes 00,01,10 timers one-three; 11 fourth/reserved
// RULE_13: Synchronous rising-edge capture loads both bytes together
`timescale 1ns/1ps
`default_nettype none
module cvt_value_trigger
   import cvt_pkg::*;
#(
   parameter bit FOURTH_TIMER = 1'b1  // fourth 8-bit timer present
) (
   input  wire logic           clk_i,
   input  wire logic           rst_n_i,
   input  wire logic [4:0]     avs_address_i,
   input  wire logic           avs_read_i,
   input  wire logic           avs_write_i,
   input  wire logic [31:0]    avs_writedata_i,
   input  wire logic [3:0]     avs_byteenable_i,
   output logic      [31:0]    avs_readdata_o,
   output logic                avs_waitrequest_o,
   input  wire logic [15:0]    sixteen_bit_timer_i,
   input  wire cvt_trig_type   trig_i,
   input  wire cvt_timers_type timers_i,
   output logic                compare_match_o,
   output logic                capture_event_o,
   output logic      [9:0]     pulse_width_value_o,
   output logic      [7:0]     pwm_timebase_o,
   output logic      [1:0]     pwm_mode_o
);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [7:0]   vlow_r, vlow_nxt;         // value_low_byte
   logic [7:0]   vhigh_r, vhigh_nxt;       // value_high_byte
   logic [3:0]   trig_r, trig_nxt;         // trigger_source_register field
   cvt_mode_type mode_r, mode_nxt;         // operating mode
   logic         fmt_r, fmt_nxt;           // alignment_format_bit
   logic [7:0]   tbase_r, tbase_nxt;       // timebase_select_register
   logic         cap_seen_r, cap_seen_nxt; // sticky capture status
   logic [31:0]  rdata_r, rdata_nxt;       // registered read data
   logic         ack_r, ack_nxt;           // one wait cycle per access
   logic         wait_r, wait_nxt;         // waitrequest, high while idle
   logic         trig_d_r;                 // previous trigger level
   logic         match_r, match_nxt;       // compare match, one cycle late
   logic         cap_ev_r;                 // one-cycle capture pulse
   logic [9:0]   pw_r, pw_nxt;             // registered pulse width
   logic [7:0]   tb_r, tb_nxt;             // registered timebase value

   logic         trig_lvl;                 // selected trigger level
   logic         cap_fire;                 // capture this cycle
   logic         wr_hit;                   // write taken this edge

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Trigger source mux; reserved codes give no trigger
   function automatic logic trig_sel(input logic [3:0] code, input cvt_trig_type t);
      logic v;
      v = 1'b0;
      if (code == CVT_TRIG_PIN) begin
         v = t.mapped_pin;                                  // [RULE_07]
      end else if (code >= CVT_TRIG_CMP1 && code <= CVT_TRIG_CMP6) begin
         v = t.comparator_synced_output[3'(code - CVT_TRIG_CMP1)]; // [RULE_06]
      end else if (code >= CVT_TRIG_LC1 && code <= CVT_TRIG_LC4) begin
         v = t.logic_cell_output[2'(code - CVT_TRIG_LC1)];  // [RULE_06]
      end else if (code == CVT_TRIG_PCHG) begin
         v = t.pin_change_event;                            // [RULE_06]
      end
      return v;
   endfunction

   // Timer select by two-bit code; fourth code reserved when absent
   // Reserved code reads as a stopped timer, so PWM simply never counts
   function automatic logic [7:0] timer_sel(input logic [1:0] code, input cvt_timers_type tm);
      logic [7:0] v;
      v = 8'h00;
      unique case (code)
         2'h0: v = tm.t0;                                   // [RULE_12]
         2'h1: v = tm.t1;
         2'h2: v = tm.t2;
         2'h3: v = FOURTH_TIMER ? tm.t3 : 8'h00;            // [RULE_12]
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // Trigger selection and edge detection
   // ------------------------------------------------------------
   // Inputs are already synchronous; rising edge marks an event
   always_comb begin
      trig_lvl = trig_sel(trig_r, trig_i);
      cap_fire = (mode_r == CVT_MODE_CAPTURE) && trig_lvl && !trig_d_r; // [RULE_13]
      wr_hit   = avs_write_i && ack_r;
   end

   // ------------------------------------------------------------
   // Register file next state
   // ------------------------------------------------------------
   // Capture overrides a same-cycle software write to the value bytes,
   // so a hardware event is never lost.
   always_comb begin
      vlow_nxt     = vlow_r;
      vhigh_nxt    = vhigh_r;
      trig_nxt     = trig_r;
      mode_nxt     = mode_r;
      fmt_nxt      = fmt_r;
      tbase_nxt    = tbase_r;
      cap_seen_nxt = cap_seen_r;
      if (wr_hit && avs_byteenable_i[0]) begin
         unique case (avs_address_i)
            {1'b0, CVT_ADDR_VLOW}:  vlow_nxt  = avs_writedata_i[7:0];
            {1'b0, CVT_ADDR_VHIGH}: vhigh_nxt = avs_writedata_i[7:0];
            {1'b0, CVT_ADDR_TRIG}:  trig_nxt  = avs_writedata_i[3:0]; // [RULE_08]
            {1'b0, CVT_ADDR_CTRL}: begin
               mode_nxt = cvt_mode_type'(avs_writedata_i[1:0]);
               fmt_nxt  = avs_writedata_i[CVT_FMT_POS];
            end
            CVT_WORD_TBASE: tbase_nxt = avs_writedata_i[7:0];        // [RULE_10]
            CVT_WORD_STAT:  cap_seen_nxt = 1'b0;
            default: ;
         endcase
      end
      if (cap_fire) begin
         vlow_nxt     = sixteen_bit_timer_i[7:0];                    // [RULE_01] [RULE_13]
         vhigh_nxt    = sixteen_bit_timer_i[15:8];                   // [RULE_01] [RULE_13]
         cap_seen_nxt = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Bus answer: waitrequest high one cycle, then read data stands
   // ------------------------------------------------------------
   // Waitrequest has its own flop so the port leaves a register directly;
   // it must read high during reset, hence a reset value of one.
   always_comb begin
      ack_nxt   = (avs_read_i || avs_write_i) && !ack_r;
      wait_nxt  = !ack_nxt;
      rdata_nxt = rdata_r;
      if (avs_read_i && !ack_r) begin
         unique case (avs_address_i)
            {1'b0, CVT_ADDR_VLOW}:  rdata_nxt = {24'h0, vlow_r};
            {1'b0, CVT_ADDR_VHIGH}: rdata_nxt = {24'h0, vhigh_r};
            {1'b0, CVT_ADDR_TRIG}:  rdata_nxt = {28'h0, trig_r};     // [RULE_08]
            {1'b0, CVT_ADDR_CTRL}:  rdata_nxt = {29'h0, fmt_r, mode_r};
            CVT_WORD_TBASE:         rdata_nxt = {24'h0, tbase_r};
            CVT_WORD_STAT:          rdata_nxt = {30'h0, cap_seen_r, match_r};
            default:                rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Compare, pulse width and timebase outputs
   // ------------------------------------------------------------
   // Width and timebase are decoded every cycle; mode only gates the match
   always_comb begin
      match_nxt = (mode_r == CVT_MODE_COMPARE) &&
                  ({vhigh_r, vlow_r} == sixteen_bit_timer_i);        // [RULE_02]
      if (fmt_r) begin
         pw_nxt = {vhigh_r, vlow_r[7:6]};                             // [RULE_04] [RULE_05]
      end else begin
         pw_nxt = {vhigh_r[1:0], vlow_r};                             // [RULE_03]
      end
      tb_nxt = timer_sel(tbase_r[1:0], timers_i);                     // [RULE_11]
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   // One register bank for all state; every reset loads it alike,
   // so power-on and later resets need no separate handling.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vlow_r     <= CVT_RST_BYTE;                                  // [RULE_09]
         vhigh_r    <= CVT_RST_BYTE;                                  // [RULE_09]
         trig_r     <= CVT_RST_TRIG;                                  // [RULE_09]
         mode_r     <= CVT_MODE_OFF;
         fmt_r      <= 1'b0;
         tbase_r    <= CVT_RST_BYTE;
         cap_seen_r <= 1'b0;
         rdata_r    <= 32'h0000_0000;
         ack_r      <= 1'b0;
         wait_r     <= 1'b1;
         trig_d_r   <= 1'b0;
         match_r    <= 1'b0;
         cap_ev_r   <= 1'b0;
         pw_r       <= 10'h000;
         tb_r       <= 8'h00;
      end else begin
         vlow_r     <= vlow_nxt;
         vhigh_r    <= vhigh_nxt;
         trig_r     <= trig_nxt;
         mode_r     <= mode_nxt;
         fmt_r      <= fmt_nxt;
         tbase_r    <= tbase_nxt;
         cap_seen_r <= cap_seen_nxt;
         rdata_r    <= rdata_nxt;
         ack_r      <= ack_nxt;
         wait_r     <= wait_nxt;
         trig_d_r   <= trig_lvl;
         match_r    <= match_nxt;
         cap_ev_r   <= cap_fire;
         pw_r       <= pw_nxt;
         tb_r       <= tb_nxt;
      end
   end

   // Every port is a plain copy of a flop; no gates after the registers
   assign avs_readdata_o      = rdata_r;
   assign avs_waitrequest_o   = wait_r;
   assign compare_match_o     = match_r;
   assign capture_event_o     = cap_ev_r;
   assign pulse_width_value_o = pw_r;
   assign pwm_timebase_o      = tb_r;
   assign pwm_mode_o          = mode_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Named steps shared by the properties below
   sequence cap_edge_s;
      (mode_r == CVT_MODE_CAPTURE) && trig_lvl && !trig_d_r;
   endsequence

   sequence tb_write_s;
      wr_hit && avs_byteenable_i[0] && (avs_address_i == CVT_WORD_TBASE);
   endsequence

   cap_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_01]
      cap_edge_s |=> {vhigh_r, vlow_r} == $past(sixteen_bit_timer_i))
      else $error("capture value not loaded");
   cmp_match_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_02]
      (mode_r == CVT_MODE_COMPARE && {vhigh_r, vlow_r} == sixteen_bit_timer_i) |=> compare_match_o)
      else $error("compare match missed");
   pw_right_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_03]
      !fmt_r |=> pulse_width_value_o == {$past(vhigh_r[1:0]), $past(vlow_r)})
      else $error("right aligned width wrong");
   pw_left_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_04]
      fmt_r |=> pulse_width_value_o[9:2] == $past(vhigh_r))
      else $error("left aligned high bits wrong");
   pw_left_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_05]
      fmt_r |=> pulse_width_value_o[1:0] == $past(vlow_r[7:6]))
      else $error("left aligned low bits wrong");
   trig_pin_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_07]
      trig_r == CVT_TRIG_PIN |-> trig_lvl == trig_i.mapped_pin)
      else $error("pin trigger not selected");
   trig_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_06]
      (trig_r == 4'h7 || trig_r == 4'h8 || trig_r > CVT_TRIG_PCHG) |-> !trig_lvl)
      else $error("reserved trigger code active");
   trig_upper_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_08]
      (avs_read_i && !ack_r && avs_address_i == {1'b0, CVT_ADDR_TRIG}) |=> avs_readdata_o[31:4] == 28'h0)
      else $error("trigger upper bits not zero");
   tbase_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_12]
      tbase_r[1:0] == 2'h1 |=> pwm_timebase_o == $past(timers_i.t1))
      else $error("timebase code one wrong");
   // Edges cannot follow one another, as the delayed level is then high
   cap_event_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_13]
      cap_edge_s |=> capture_event_o ##1 !capture_event_o)
      else $error("capture pulse wrong");
   cap_status_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_13]
      cap_edge_s |=> cap_seen_r)
      else $error("capture status not set");

   // Reset clears value bytes and trigger field, whatever came before
   rst_clear_a: assert property (@(posedge clk_i) // [RULE_09]
      !rst_n_i |=> vlow_r == 8'h00 && vhigh_r == 8'h00 && trig_r == 4'h0)
      else $error("registers not cleared by reset");

   // Trigger decode for comparator and logic-cell codes
   trig_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_06]
      (trig_r >= CVT_TRIG_CMP1 && trig_r <= CVT_TRIG_CMP6) |->
      trig_lvl == trig_i.comparator_synced_output[trig_r[2:0] - 3'h1])
      else $error("comparator trigger not selected");
   trig_cell_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_06]
      (trig_r >= CVT_TRIG_LC1 && trig_r <= CVT_TRIG_LC4) |->
      trig_lvl == trig_i.logic_cell_output[trig_r[1:0] - 2'h1])
      else $error("logic cell trigger not selected");

   // Timebase decode, one property per code, and the select write
   tbase_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_12]
      tbase_r[1:0] == 2'h0 |=> pwm_timebase_o == $past(timers_i.t0))
      else $error("timebase code zero wrong");
   tbase_two_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_11]
      tbase_r[1:0] == 2'h2 |=> pwm_timebase_o == $past(timers_i.t2))
      else $error("timebase code two wrong");
   tbase_four_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_12]
      tbase_r[1:0] == CVT_CODE_FOURTH |=> pwm_timebase_o == (FOURTH_TIMER ? $past(timers_i.t3) : 8'h00))
      else $error("timebase code three wrong");
   tbase_wr_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_10]
      tb_write_s |=> tbase_r == $past(avs_writedata_i[7:0]))
      else $error("timebase select not stored");

endmodule
`default_nettype wire

// [verif/cvt_partner.sv]
// Model of the timers and trigger sources that face the value/trigger block
`timescale 1ns/1ps
`default_nettype none
module cvt_partner
   import cvt_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        run_i,        // Timers count only while high
   input  wire logic [11:0] trig_src_i,   // Raw trigger levels from the bench
   output logic      [15:0] timer16_o,
   output cvt_trig_type     trig_o,
   output cvt_timers_type   timers_o
);
   // ------------------------------------------
   // Free counters, each with its own step
   // ------------------------------------------
   // Freezing lets the bench know the exact value at a capture
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         timer16_o <= 16'h1234;
         timers_o  <= 32'h4433_2211;
      end else if (run_i) begin
         timer16_o <= timer16_o + 16'h0b05;
         timers_o  <= timers_o + 32'h0703_0501;
      end
   end
   // Trigger sources are levels, packed in struct order
   assign trig_o = cvt_trig_type'(trig_src_i);
endmodule
`default_nettype wire

// [verif/cvt_value_trigger_tb.sv]
// Self-checking bench for the value registers and trigger/timebase select
`timescale 1ns/1ps
`default_nettype none
module cvt_value_trigger_tb;
   import cvt_pkg::*;
   // ------------------------------------------
   // Signals and counters
   // ------------------------------------------
   localparam logic [4:0] A_LO = {1'b0, CVT_ADDR_VLOW};
   localparam logic [4:0] A_HI = {1'b0, CVT_ADDR_VHIGH};
   localparam logic [4:0] A_TR = {1'b0, CVT_ADDR_TRIG};
   localparam logic [4:0] A_CT = {1'b0, CVT_ADDR_CTRL};
   logic clk, rst_n, rd, wr, run, wtq, match, cev;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, rv;
   logic [11:0] src;
   logic [15:0] t16;
   logic [9:0] pw;
   logic [7:0] tb;
   logic [1:0] pm;
   cvt_trig_type trg;
   cvt_timers_type tmr;
   int n_mismatch = 0;
   int n_compared = 0;
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   cvt_partner i_cvt_partner (.clk_i(clk), .rst_n_i(rst_n), .run_i(run), .trig_src_i(src),
      .timer16_o(t16), .trig_o(trg), .timers_o(tmr));
   cvt_value_trigger i_cvt_value_trigger (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wtq), .sixteen_bit_timer_i(t16), .trig_i(trg),
      .timers_i(tmr), .compare_match_o(match), .capture_event_o(cev),
      .pulse_width_value_o(pw), .pwm_timebase_o(tb), .pwm_mode_o(pm));
   // ------------------------------------------
   // Shared tasks
   // ------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // One Avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (wtq !== 1'b0);
      chk("bus_wait", k, 2);
      rv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Trigger source bit for a select code
   function automatic int sbit(input int c);
      if (c == 0) return 0;
      if (c <= 6) return c + 5;
      if (c == 13) return 1;
      return c - 7;
   endfunction
   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   task automatic t_reset_vals;
      bus(0, A_LO, 0); chk("value_low", rv, 0);
      bus(0, A_HI, 0); chk("value_high", rv, 0);
      bus(0, A_TR, 0); chk("trig_select", rv, 0);
      bus(0, 5'h18, 0); chk("unmapped", rv, 0);
      chk("pulse_width", pw, 0);
   endtask
   task automatic t_trig_reg;
      bus(1, A_TR, 32'hfd);
      bus(0, A_TR, 0); chk("trig_upper", rv, 32'h0d);
   endtask
   task automatic t_pwm;
      bus(1, A_LO, 32'hc5);
      bus(1, A_HI, 32'ha7);
      bus(1, A_CT, 32'h3);
      cyc(3);
      chk("pwm_mode", pm, 32'h3);
      chk("width_right", pw, 32'h3c5);
      bus(1, A_CT, 32'h7);
      cyc(3);
      chk("width_left", pw, 32'h29f);
      bus(1, A_LO, 32'h3a);
      cyc(3);
      chk("width_left_low", pw, 32'h29c);
   endtask
   // Each code picks its timer; other units' bits read back untouched
   task automatic t_timebase;
      logic [7:0] d;
      for (int c = 0; c < 4; c++) begin
         d = {6'h39 ^ 6'(c), 2'(c)};
         bus(1, CVT_WORD_TBASE, {24'h0, d});
         bus(0, CVT_WORD_TBASE, 0); chk("timebase_reg", rv, {24'h0, d});
         cyc(3);
         chk("timebase_sel", tb, tmr[8*c +: 8]);
      end
   endtask
   task automatic t_compare;
      bus(1, A_CT, 32'h2);
      bus(1, A_LO, {24'h0, t16[7:0]});
      bus(1, A_HI, {24'h0, t16[15:8]});
      cyc(3);
      chk("match_equal", match, 1);
      bus(0, CVT_WORD_STAT, 0);
      chk("status_match", rv, 32'h1);
      bus(1, A_HI, {24'h0, t16[15:8] ^ 8'h80});
      cyc(3);
      chk("match_high_diff", match, 0);
   endtask
   // Codes 0 to 13, reserved 7 and 8 included, with a fresh frozen timer
   task automatic t_capture;
      logic [15:0] e;
      logic hit;
      bus(1, A_CT, 32'h1);
      for (int c = 0; c < 14; c++) begin
         bus(1, A_TR, c);
         run <= 1'b1;
         cyc(3);
         run <= 1'b0;
         cyc(1);
         e = t16;
         hit = 0;
         src[sbit(c)] <= 1'b1;
         repeat (5) begin
            @(posedge clk);
            if (cev === 1'b1) hit = 1;
         end
         chk("capture_seen", hit, (c != 7 && c != 8));
         if (hit) begin
            bus(0, A_LO, 0); chk("capt_low", rv, e[7:0]);
            bus(0, A_HI, 0); chk("capt_high", rv, e[15:8]);
            bus(0, CVT_WORD_STAT, 0);
            chk("capt_status", rv, 32'h2);
            bus(1, CVT_WORD_STAT, 0);
            bus(0, CVT_WORD_STAT, 0);
            chk("status_clear", rv, 32'h0);
         end
         src <= 12'h0;
      end
   endtask
   // ------------------------------------------
   // Verdict and main sequence
   // ------------------------------------------
   task automatic results;
      $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      rst_n = 0; rd = 0; wr = 0; run = 0; adr = 0; wdat = 0; src = 0;
      cyc(12);
      rst_n <= 1'b1;
      t_reset_vals;
      t_trig_reg;
      t_pwm;
      t_timebase;
      t_compare;
      t_capture;
      // Second reset in mid-run must clear the value bytes, trigger select and pulse width again
      rst_n <= 1'b0;
      cyc(3);
      rst_n <= 1'b1;
      t_reset_vals;
      results;
   end
   // Watchdog well beyond the few hundred cycles the run needs
   initial begin
      #(40 * 20000);
      n_mismatch++;
      results;
   end
endmodule
`default_nettype wire
